// [core/dbp_host.sv]
// Host end: divides the link clock, issues two-word bursts and collects read words.
`timescale 1ns/100ps
module dbp_host
  import dbp_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W,
  parameter int KH = K_HALF_CYCLES
) (
  dbp_if.host link,
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic [DW-1:0] req_wdata0_i,
  input wire logic [DW-1:0] req_wdata1_i,
  input wire logic [DW/LANE_W-1:0] req_lane_n0_i,
  input wire logic [DW/LANE_W-1:0] req_lane_n1_i,
  input wire logic pll_disable_n_i,
  output logic rd_valid_o,
  output logic [DW-1:0] rd_data0_o,
  output logic [DW-1:0] rd_data1_o
);
  localparam int NL = DW / LANE_W;
  localparam int PH_W = $clog2(2 * KH);

  logic [PH_W-1:0] ph_ff;
  logic k_ff;
  logic kn_ff;
  dbp_hstate_t st_ff;
  logic [2:0] cyc_ff;
  logic wr_ff;
  logic [DW-1:0] w1_ff;
  logic [NL-1:0] ln1_ff;
  logic strobe_n_ff;
  logic rnw_ff;
  logic [AW-1:0] addr_ff;
  logic [NL-1:0] lane_n_ff;
  logic [DW-1:0] dq_ff;
  logic dq_oe_ff;
  logic pll_n_ff;
  logic [DW-1:0] s1_ff;
  logic [DW-1:0] s2_ff;
  logic [DW-1:0] rd0_ff;
  logic [DW-1:0] rd1_ff;
  logic rdv_ff;

  // Phase points within one link cycle; phases 0..KH-1 are K high.
  wire [PH_W-1:0] nxt_ph = (ph_ff == PH_W'(2 * KH - 1)) ? '0 : ph_ff + PH_W'(1);
  wire mid_high_w = (ph_ff == PH_W'(KH / 2));
  wire mid_low_w = (ph_ff == PH_W'(KH + KH / 2));
  wire end_high_w = (ph_ff == PH_W'(KH - 1));
  wire end_low_w = (ph_ff == PH_W'(2 * KH - 1));
  wire smp0_w = pll_n_ff ? (end_low_w && cyc_ff == 3'(SMP0_CYC_PLL)) : (end_high_w && cyc_ff == 3'(SMP0_CYC_OFF));
  wire smp1_w = pll_n_ff ? (end_high_w && cyc_ff == 3'(SMP1_CYC_PLL)) : (end_low_w && cyc_ff == 3'(SMP1_CYC_OFF));

  assign req_ready_o = (st_ff == HS_IDLE) && mid_low_w;
  assign link.k = k_ff;
  assign link.kn = kn_ff;
  assign link.bus_cycle_strobe_n = strobe_n_ff;
  assign link.read_not_write = rnw_ff;
  assign link.addr = addr_ff;
  assign link.byte_lane_write_n = lane_n_ff;
  assign link.dq_h2d = dq_ff;
  assign link.dq_h_oe = dq_oe_ff;
  assign link.pll_disable_n = pll_n_ff;
  assign rd_valid_o = rdv_ff;
  assign rd_data0_o = rd0_ff;
  assign rd_data1_o = rd1_ff;

  // Read pins come back through two flip-flops before the capture point reads them.
  always_ff @(posedge clk_i) begin
    s1_ff <= link.dq_bus;
    s2_ff <= s1_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ph_ff <= '0;
      k_ff <= 1'b0;
      kn_ff <= 1'b1;
      pll_n_ff <= RST_PLL_DISABLE_N;
    end else begin
      ph_ff <= nxt_ph;
      k_ff <= (nxt_ph < PH_W'(KH));
      kn_ff <= !(nxt_ph < PH_W'(KH));
      pll_n_ff <= pll_disable_n_i;
    end
  end

  // Pins change mid-half so they are settled at the K or K-bar rise that samples them.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_ff <= HS_IDLE;
      cyc_ff <= '0;
      wr_ff <= 1'b0;
      w1_ff <= '0;
      ln1_ff <= '1;
      strobe_n_ff <= RST_STROBE_N;
      rnw_ff <= 1'b1;
      addr_ff <= '0;
      lane_n_ff <= '1;
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
      rd0_ff <= '0;
      rd1_ff <= '0;
      rdv_ff <= 1'b0;
    end else begin
      rdv_ff <= 1'b0;
      unique case (st_ff)
        HS_IDLE: begin
          if (req_valid_i && mid_low_w) begin
            strobe_n_ff <= 1'b0;
            rnw_ff <= !req_write_i;
            addr_ff <= req_addr_i;
            wr_ff <= req_write_i;
            dq_ff <= req_wdata0_i;
            // A read leaves every lane deselected.
            lane_n_ff <= req_write_i ? req_lane_n0_i : '1;
            w1_ff <= req_wdata1_i;
            ln1_ff <= req_lane_n1_i;
            st_ff <= HS_LOAD;
          end
        end
        HS_LOAD: begin
          if (mid_high_w) begin
            strobe_n_ff <= 1'b1;
            cyc_ff <= '0;
            st_ff <= wr_ff ? HS_WR0 : HS_RD;
          end
        end
        HS_WR0: begin
          if (mid_low_w) begin
            dq_oe_ff <= 1'b1;
            st_ff <= HS_WR1;
          end
        end
        HS_WR1: begin
          if (mid_high_w) begin
            dq_ff <= w1_ff;
            lane_n_ff <= ln1_ff;
            st_ff <= HS_WR2;
          end
        end
        HS_WR2: begin
          if (mid_low_w) begin
            dq_oe_ff <= 1'b0;
            lane_n_ff <= '1;
            st_ff <= HS_IDLE;
          end
        end
        HS_RD: begin
          if (end_low_w) begin
            cyc_ff <= cyc_ff + 3'(1);
          end
          if (smp0_w) begin
            rd0_ff <= s2_ff;
          end
          if (smp1_w) begin
            rd1_ff <= s2_ff;
            rdv_ff <= 1'b1;
            st_ff <= HS_IDLE;
          end
        end
        default: begin
          st_ff <= HS_IDLE;
        end
      endcase
    end
  end

endmodule // dbp_host

// [core/dbp_pkg.sv]
// Shared constants and types of the two-word-burst DDR SRAM bus port.
package dbp_pkg;

  // Narrow organisation: 18-bit words, two 9-bit lanes, 2M burst locations.
  localparam int DATA_W = 18;
  localparam int ADDR_W = 21;
  localparam int LANE_W = 9;
  localparam int LANES = DATA_W / LANE_W;
  localparam int BURST_LEN = 2;

  // Host clock and the link clock that the host divides from it.
  localparam int CLK_PERIOD_NS = 5;
  localparam int K_HALF_CYCLES = 4;
  localparam int K_PERIOD_NS = 2 * K_HALF_CYCLES * CLK_PERIOD_NS;

  // Whole link cycles after the load edge at which the host takes each read word.
  localparam int SMP0_CYC_PLL = 2;
  localparam int SMP1_CYC_PLL = 3;
  localparam int SMP0_CYC_OFF = 1;
  localparam int SMP1_CYC_OFF = 1;

  // Values loaded at reset.
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic RST_PLL_DISABLE_N = 1'b1;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LOAD = 3'b001,
    HS_WR0 = 3'b010,
    HS_WR1 = 3'b011,
    HS_WR2 = 3'b100,
    HS_RD = 3'b101
  } dbp_hstate_t;

endpackage

// [core/dbp_if.sv]
// Pin bundle between the memory controller and the burst SRAM bus port.
`timescale 1ns/100ps
interface dbp_if #(
  parameter int DW = 18,
  parameter int AW = 21,
  parameter int LN = 2
);
  logic k;
  logic kn;
  logic bus_cycle_strobe_n;
  logic read_not_write;
  logic [AW-1:0] addr;
  logic [LN-1:0] byte_lane_write_n;
  logic [DW-1:0] dq_h2d;
  logic dq_h_oe;
  logic [DW-1:0] dq_d2h;
  logic dq_d_oe;
  logic [DW-1:0] dq_bus;
  logic echo_timing_out;
  logic echo_timing_out_n;
  logic read_output_valid;
  logic pll_disable_n;

  // Resolved level of the shared data pins. With nobody driving, the pins show the
  // inverse of the device's last word, so that a capture from a floating bus is caught.
  assign dq_bus = dq_d_oe ? dq_d2h : (dq_h_oe ? dq_h2d : ~dq_d2h);

  modport host (
    output k, kn, bus_cycle_strobe_n, read_not_write, addr, byte_lane_write_n, dq_h2d, dq_h_oe, pll_disable_n,
    input dq_bus, echo_timing_out, echo_timing_out_n, read_output_valid
  );

  modport dev (
    input k, kn, bus_cycle_strobe_n, read_not_write, addr, byte_lane_write_n, dq_bus, pll_disable_n,
    output dq_d2h, dq_d_oe, echo_timing_out, echo_timing_out_n, read_output_valid
  );
endinterface

// [core/dbp_mem.sv]
// One half-depth storage array with per-lane write enables and a flat read port.
`timescale 1ns/100ps
module dbp_mem
  import dbp_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [DW/LANE_W-1:0] wlane_n_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  localparam int NL = DW / LANE_W;

  logic [DW-1:0] mem_ff [2**AW];

  assign rdata_o = mem_ff[raddr_i];

  // A lane whose select is high keeps its old contents.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NL; i++) begin
      if (we_i && !wlane_n_i[i]) begin
        mem_ff[waddr_i][i*LANE_W +: LANE_W] <= wdata_i[i*LANE_W +: LANE_W];
      end
    end
  end

endmodule // dbp_mem

// [core/dbp_device.sv]
// Device end of the burst SRAM bus port: capture, storage and double-edge read launch.
//
// What this block does
// - Write words captured on K and K-bar rises.
// - Read words launched on K and K-bar rises.
// - Data drivers float whenever no read selected.
// - Host lowers load strobe; sampled on K rise.
// - Every access moves exactly two words.
// - Read/write select: high read, low write.
// - One shared address bus sampled on K.
// - Storage split into two half-depth arrays.
// - Host may permute address bits freely.
// - Lane selects sampled on both clock rises.
// - Each lane select governs one 9-bit lane.
// - Lane select sampled with its own word.
// - Deselected lane keeps stored contents unchanged.
// - Valid flag high while read data driven.
// - Accesses start only on K rising edge.
// - K-bar captures writes and launches reads.
// - Echo clocks run free, following K.
// - PLL disabled gives one-cycle DDR timing.
`timescale 1ns/100ps
module dbp_device
  import dbp_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  dbp_if.dev link,
  input wire logic reset_n_i,
  output logic pll_off_o
);
  localparam int NL = DW / LANE_W;

  // Mode-dependent picks; the first argument is the PLL-off flag.
  function automatic logic pick_bit(input logic off, input logic when_off, input logic when_on);
    return off ? when_off : when_on;
  endfunction

  function automatic logic [AW-1:0] pick_addr(input logic off, input logic [AW-1:0] when_off,
                                              input logic [AW-1:0] when_on);
    return off ? when_off : when_on;
  endfunction

  function automatic logic [DW-1:0] pick_word(input logic off, input logic [DW-1:0] when_off,
                                              input logic [DW-1:0] when_on);
    return off ? when_off : when_on;
  endfunction

  // The pins show the K-launched register while K is high, the K-bar one otherwise.
  function automatic logic half_bit(input logic k_high, input logic from_k, input logic from_kn);
    return k_high ? from_k : from_kn;
  endfunction

  // Reset and mode strap enter the link domain through two flip-flops.
  logic rst_meta_ff;
  logic rst_n_ff;
  logic pll_meta_ff;
  logic pll_off_ff;

  always_ff @(posedge link.k) begin
    rst_meta_ff <= reset_n_i;
    rst_n_ff <= rst_meta_ff;
  end

  // The mode strap comes from the host's clock and is retimed the same way.
  always_ff @(posedge link.k) begin
    pll_meta_ff <= ~link.pll_disable_n;
    pll_off_ff <= pll_meta_ff;
  end

  assign pll_off_o = pll_off_ff;

  // Load decode on the K rise; the address is the same bus for both directions.
  // Storage is addressed by the bus word as a whole, so any bit order works.
  wire load_w = ~link.bus_cycle_strobe_n;
  wire load_rd_w = load_w & link.read_not_write;
  wire load_wr_w = load_w & ~link.read_not_write;

  // Read pipeline, one stage per K cycle after the load edge.
  logic rd_v1_ff;
  logic rd_v2_ff;
  logic rd_v3_ff;
  logic [AW-1:0] ra1_ff;
  logic [AW-1:0] ra2_ff;
  logic [AW-1:0] ra3_ff;

  // Write pipeline: first word at the next K rise, second at the K-bar rise after.
  logic wr_v1_ff;
  logic wr_v2_ff;
  logic [AW-1:0] wa1_ff;
  logic [AW-1:0] wa2_ff;

  always_ff @(posedge link.k) begin
    if (!rst_n_ff) begin
      rd_v1_ff <= 1'b0;
      rd_v2_ff <= 1'b0;
      rd_v3_ff <= 1'b0;
      ra1_ff <= '0;
      ra2_ff <= '0;
      ra3_ff <= '0;
    end else begin
      rd_v1_ff <= load_rd_w;
      rd_v2_ff <= rd_v1_ff;
      rd_v3_ff <= rd_v2_ff;
      ra1_ff <= link.addr;
      ra2_ff <= ra1_ff;
      ra3_ff <= ra2_ff;
    end
  end

  // Changing the mode strap while a read is in flight garbles that read only.
  always_ff @(posedge link.k) begin
    if (!rst_n_ff) begin
      wr_v1_ff <= 1'b0;
      wr_v2_ff <= 1'b0;
      wa1_ff <= '0;
      wa2_ff <= '0;
    end else begin
      wr_v1_ff <= load_wr_w;
      wr_v2_ff <= wr_v1_ff;
      wa1_ff <= link.addr;
      wa2_ff <= wa1_ff;
    end
  end

  // Array 0 holds the first word of each burst, array 1 the second.
  logic [DW-1:0] arr0_rdata;
  logic [DW-1:0] arr1_rdata;
  wire [AW-1:0] arr0_raddr_w = pick_addr(pll_off_ff, ra1_ff, ra3_ff);
  wire [AW-1:0] arr1_raddr_w = pick_addr(pll_off_ff, ra2_ff, ra3_ff);

  // First word and its lane selects are taken on the K rise.
  dbp_mem #(
    .DW(DW),
    .AW(AW)
  ) u_arr0 (
    .clk_i(link.k),
    .we_i(wr_v1_ff),
    .waddr_i(wa1_ff),
    .wdata_i(link.dq_bus),
    .wlane_n_i(link.byte_lane_write_n),
    .raddr_i(arr0_raddr_w),
    .rdata_o(arr0_rdata)
  );

  // Second word and its own lane selects are taken on the K-bar rise.
  dbp_mem #(
    .DW(DW),
    .AW(AW)
  ) u_arr1 (
    .clk_i(link.kn),
    .we_i(wr_v2_ff),
    .waddr_i(wa2_ff),
    .wdata_i(link.dq_bus),
    .wlane_n_i(link.byte_lane_write_n),
    .raddr_i(arr1_raddr_w),
    .rdata_o(arr1_rdata)
  );

  // Launch selection. With the PLL on, word 0 leaves at the K-bar rise 2.5 cycles
  // after the load and word 1 at the following K rise. With it off, word 0 leaves
  // at the next K rise and word 1 at the K-bar rise after that.
  wire launch_k_w = pick_bit(pll_off_ff, rd_v1_ff, rd_v3_ff);
  wire [DW-1:0] word_k_w = pick_word(pll_off_ff, arr0_rdata, arr1_rdata);
  wire launch_kn_w = pick_bit(pll_off_ff, rd_v2_ff, rd_v3_ff);
  wire [DW-1:0] word_kn_w = pick_word(pll_off_ff, arr1_rdata, arr0_rdata);

  logic [DW-1:0] q_k_ff;
  logic oe_k_ff;
  logic vld_k_ff;
  logic [DW-1:0] q_kn_ff;
  logic oe_kn_ff;
  logic vld_kn_ff;

  always_ff @(posedge link.k) begin
    if (!rst_n_ff) begin
      q_k_ff <= '0;
      oe_k_ff <= 1'b0;
      vld_k_ff <= 1'b0;
    end else begin
      q_k_ff <= word_k_w;
      oe_k_ff <= launch_k_w;
      vld_k_ff <= launch_k_w;
    end
  end

  // The K-bar half shares the K-domain reset; both edges belong to one link clock.
  always_ff @(posedge link.kn) begin
    if (!rst_n_ff) begin
      q_kn_ff <= '0;
      oe_kn_ff <= 1'b0;
      vld_kn_ff <= 1'b0;
    end else begin
      q_kn_ff <= word_kn_w;
      oe_kn_ff <= launch_kn_w;
      vld_kn_ff <= launch_kn_w;
    end
  end

  // While K is high the K-launched word is on the pins, while it is low the
  // K-bar-launched word; each register only changes at the edge that hands over.
  // The valid flag has flops of its own and hands over on the same edges as the
  // echo clocks, so it rises and falls in step with them.
  assign link.dq_d2h = link.k ? q_k_ff : q_kn_ff;
  assign link.dq_d_oe = half_bit(link.k, oe_k_ff, oe_kn_ff);
  assign link.read_output_valid = half_bit(link.k, vld_k_ff, vld_kn_ff);

  // Echo clocks follow the input clock pair without interruption.
  assign link.echo_timing_out = link.k;
  assign link.echo_timing_out_n = link.kn;

endmodule // dbp_device

// [verification/dbp_checker.sv]
// Link-side concurrent checks of the burst SRAM bus port.
`timescale 1ns/100ps
module dbp_checker #(
  parameter int LN = 2
) (
  input wire logic k_i,
  input wire logic reset_n_i,
  input wire logic bus_cycle_strobe_n_i,
  input wire logic read_not_write_i,
  input wire logic [LN-1:0] byte_lane_write_n_i,
  input wire logic dq_h_oe_i,
  input wire logic dq_d_oe_i,
  input wire logic echo_timing_out_i,
  input wire logic echo_timing_out_n_i,
  input wire logic read_output_valid_i,
  input wire logic pll_disable_n_i
);
  wire rd_ld = !bus_cycle_strobe_n_i && read_not_write_i;
  wire wr_ld = !bus_cycle_strobe_n_i && !read_not_write_i;
  default clocking cb @(posedge k_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence drv_win_s;
    dq_d_oe_i ##1 !dq_d_oe_i;
  endsequence
  sequence vld_win_s;
    read_output_valid_i ##1 !read_output_valid_i;
  endsequence
  sequence wr_win_s;
    dq_h_oe_i ##1 !dq_h_oe_i;
  endsequence
  rd_pll_on_a: assert property (
    rd_ld && pll_disable_n_i && $past(pll_disable_n_i, 3) |-> ##2 !dq_d_oe_i ##1 drv_win_s
  ) else $error("read window wrong with pll on");
  rd_pll_off_a: assert property (
    rd_ld && !pll_disable_n_i && !$past(pll_disable_n_i, 3) |-> ##1 !dq_d_oe_i ##1 drv_win_s
  ) else $error("read window wrong with pll off");
  vld_pll_on_a: assert property (
    rd_ld && pll_disable_n_i && $past(pll_disable_n_i, 3) |-> ##2 !read_output_valid_i ##1 vld_win_s
  ) else $error("valid window wrong with pll on");
  vld_pll_off_a: assert property (
    rd_ld && !pll_disable_n_i && !$past(pll_disable_n_i, 3) |-> ##1 !read_output_valid_i ##1 vld_win_s
  ) else $error("valid window wrong with pll off");
  valid_oe_a: assert property (
    read_output_valid_i == dq_d_oe_i
  ) else $error("valid flag differs from drive");
  drv_cause_a: assert property (
    $rose(dq_d_oe_i) |-> $past(rd_ld, 2) || $past(rd_ld, 3)
  ) else $error("data driven without a read");
  wr_float_a: assert property (
    wr_ld |-> !dq_d_oe_i [*3]
  ) else $error("device drives during write");
  strobe_gap_a: assert property (
    !bus_cycle_strobe_n_i |=> bus_cycle_strobe_n_i
  ) else $error("loads on consecutive edges");
  wr_burst_a: assert property (
    wr_ld |=> wr_win_s
  ) else $error("write burst length wrong");
  rd_host_off_a: assert property (
    rd_ld |-> !dq_h_oe_i [*4]
  ) else $error("host drives during read");
  lane_idle_a: assert property (
    bus_cycle_strobe_n_i && !dq_h_oe_i |-> &byte_lane_write_n_i
  ) else $error("lane select active when idle");
  echo_a: assert property (
    !echo_timing_out_i && echo_timing_out_n_i
  ) else $error("echo clock not following k");
endmodule // dbp_checker

// [verification/ddr_burst2_sram_bus_port_tb_top.sv]
// Self-checking bench joining host and device ends over the link.
`timescale 1ns/100ps
module ddr_burst2_sram_bus_port_tb_top;
  import dbp_pkg::*;
  localparam int AW = 6;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  logic dev_rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic pll_dis_n = 1'b1;
  logic [AW-1:0] req_addr = '0;
  logic [DATA_W-1:0] wd0 = '0;
  logic [DATA_W-1:0] wd1 = '0;
  logic [LANES-1:0] ln0 = '1;
  logic [LANES-1:0] ln1 = '1;
  logic req_ready, rd_valid, pll_off;
  logic [DATA_W-1:0] rd0, rd1;
  logic [DATA_W-1:0] m0 [2**AW];
  logic [DATA_W-1:0] m1 [2**AW];
  int error_cnt = 0;
  int samples_checked = 0;

  dbp_if #(.DW(DATA_W), .AW(AW), .LN(LANES)) lnk ();
  dbp_host #(.AW(AW)) u_dbp_host (.link(lnk), .clk_i(clk_i), .reset_n_i(rst_n),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_write_i(req_write), .req_addr_i(req_addr),
    .req_wdata0_i(wd0), .req_wdata1_i(wd1), .req_lane_n0_i(ln0), .req_lane_n1_i(ln1),
    .pll_disable_n_i(pll_dis_n), .rd_valid_o(rd_valid), .rd_data0_o(rd0), .rd_data1_o(rd1));
  dbp_device #(.AW(AW)) u_dbp_device (.link(lnk), .reset_n_i(dev_rst_n), .pll_off_o(pll_off));
  dbp_checker #(.LN(LANES)) u_dbp_checker (.k_i(lnk.k), .reset_n_i(dev_rst_n),
    .bus_cycle_strobe_n_i(lnk.bus_cycle_strobe_n), .read_not_write_i(lnk.read_not_write),
    .byte_lane_write_n_i(lnk.byte_lane_write_n), .dq_h_oe_i(lnk.dq_h_oe), .dq_d_oe_i(lnk.dq_d_oe),
    .echo_timing_out_i(lnk.echo_timing_out), .echo_timing_out_n_i(lnk.echo_timing_out_n),
    .read_output_valid_i(lnk.read_output_valid), .pll_disable_n_i(lnk.pll_disable_n));

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] old, logic [DATA_W-1:0] nw,
                                             logic [LANES-1:0] sel_n);
    for (int i = 0; i < LANES; i++) begin
      if (!sel_n[i]) old[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
    end
    return old;
  endfunction

  task automatic issue(input logic w, input logic [AW-1:0] a);
    int n;
    n = 0;
    @(negedge clk_i);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    req_valid = 1'b0;
    if (n >= 400) chk(18'h1, 18'h0);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
                    input logic [LANES-1:0] l0, input logic [LANES-1:0] l1);
    wd0 = d0;
    wd1 = d1;
    ln0 = l0;
    ln1 = l1;
    issue(1'b1, a);
    m0[a] = merge(m0[a], d0, l0);
    m1[a] = merge(m1[a], d1, l1);
  endtask

  task automatic rd(input logic [AW-1:0] a);
    int n;
    n = 0;
    issue(1'b0, a);
    while (rd_valid !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 400) chk(18'h1, 18'h0);
    chk(rd0, m0[a]);
    chk(rd1, m1[a]);
  endtask

  task automatic rnd_ops(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      if ($urandom_range(1) == 1) rd(AW'($urandom));
      else wr(AW'($urandom), DATA_W'($urandom), DATA_W'($urandom), LANES'($urandom), LANES'($urandom));
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    #300000;
    error_cnt++;
    final_report();
  end

  initial begin
    void'($urandom(58577));
    repeat (10) @(negedge clk_i);
    rst_n = 1'b1;
    // The device reset is synchronised on k, so it is held until k has run a while.
    repeat (40) @(negedge clk_i);
    dev_rst_n = 1'b1;
    repeat (64) @(negedge clk_i);
    for (int a = 0; a < 2**AW; a++) wr(AW'(a), DATA_W'($urandom), DATA_W'($urandom), '0, '0);
    wr('0, 18'h3FFFF, 18'h3FFFF, 2'b11, 2'b11);
    wr('0, 18'h2AAAA, 18'h15555, 2'b10, 2'b01);
    rd('0);
    rd('1);
    rnd_ops(80);
    pll_dis_n = 1'b0;
    repeat (40) @(negedge clk_i);
    chk({17'h0, pll_off}, 18'h1);
    rnd_ops(40);
    pll_dis_n = 1'b1;
    repeat (40) @(negedge clk_i);
    chk({17'h0, pll_off}, 18'h0);
    rnd_ops(20);
    final_report();
  end
endmodule // ddr_burst2_sram_bus_port_tb_top
